// file: pkg/pmc_pkg.sv
// Constants, field layout and carrier types of the power management control block
package pmc_pkg;
    // Register byte offsets
    localparam logic [7:0] TX_INFO_OFS = 8'h1c;
    localparam logic [7:0] CTL_OFS = 8'h20;
    localparam logic [7:0] IRQ_STS_OFS = 8'h40;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h44;
    // Control register field positions
    localparam int CAUSE_LSB = 0;
    localparam int ENERGY_EN_BIT = 2;
    localparam int LAN_EN_BIT = 3;
    localparam int PHY_RESET_REQUEST_BIT = 4;
    localparam int SUSP_LSB = 5;
    localparam int READY_BIT = 7;
    localparam int CLR_EN_BIT = 8;
    localparam int CLR_STS_BIT = 9;
    // Reset values
    localparam logic [15:0] TX_FREE_RST = 16'h2000;
    localparam logic [1:0] SUSP_RST = 2'h2;
    localparam logic CLR_EN_RST = 1'b1;
    localparam logic CLR_STS_RST = 1'b0;
    localparam logic [1:0] CAUSE_NONE = 2'h0;
    // Wake cause codes, or-ed together so that two sources give the multiple code
    localparam logic [1:0] CAUSE_ENERGY = 2'h1;
    localparam logic [1:0] CAUSE_LAN = 2'h2;
    // Suspend state numbers
    localparam logic [1:0] SUSP_TWO = 2'h2;
    localparam logic [1:0] SUSP_THREE = 2'h3;
    // Interrupt status bits
    localparam int IRQ_W = 3;
    localparam int IRQ_WAKE = 0;
    localparam int IRQ_PHY = 1;
    localparam int IRQ_READY = 2;
    // Timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int PHY_RESET_REQUEST_MIN_NS = 2000000;
    localparam int PHY_RESET_REQUEST_CYCLES = (PHY_RESET_REQUEST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum {PH_IDLE, PH_HOLD} pmc_phy_state_t;

    typedef struct packed {
        logic clr_sts;
        logic clr_en;
        logic [1:0] susp_sel;
        logic lan_en;
        logic energy_en;
        logic [1:0] cause;
    } pmc_ctl_t;

    typedef struct packed {
        logic energy;
        logic lan;
        logic good_frame;
    } pmc_wake_t;

    typedef struct packed {
        logic done;
        logic by_frame;
        logic by_remote;
    } pmc_resume_t;
endpackage : pmc_pkg

// file: core/pmc_hold_timer.sv
// Minimum hold timer that keeps the PHY in reset
`timescale 1ns/10ps
module pmc_hold_timer #(
    parameter int CYCLES = pmc_pkg::PHY_RESET_REQUEST_CYCLES
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Control
    input wire logic start,
    output logic busy,
    output logic done
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    pmc_pkg::pmc_phy_state_t state_reg;
    logic [CW-1:0] cnt_reg;
    wire logic at_end = (cnt_reg == LAST);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_reg <= pmc_pkg::PH_IDLE;
            cnt_reg <= '0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            case (state_reg)
                pmc_pkg::PH_IDLE: begin
                    cnt_reg <= '0;
                    if (start) begin
                        state_reg <= pmc_pkg::PH_HOLD;
                    end
                end
                pmc_pkg::PH_HOLD: begin
                    cnt_reg <= cnt_reg + CW'(1);
                    if (at_end) begin
                        state_reg <= pmc_pkg::PH_IDLE;
                        done <= 1'b1;
                    end
                end
                default: state_reg <= pmc_pkg::PH_IDLE;
            endcase
        end
    end

    assign busy = (state_reg == pmc_pkg::PH_HOLD);
endmodule : pmc_hold_timer

// file: core/pmc_ctrl.sv
// Power management control and status registers with Wishbone slave
//
// Implementation choice: the Wishbone register port.
`timescale 1ns/10ps
module pmc_ctrl #(
    parameter int PHY_RESET_REQUEST_CYCLES = pmc_pkg::PHY_RESET_REQUEST_CYCLES,
    parameter bit HAS_STATE3 = 1'b1
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Device state
    input wire logic [15:0] tx_free_bytes,
    input wire logic in_normal,
    input wire logic hw_cfg_done,
    input wire logic phy_clk_ok,
    input wire logic watchdog_expired,
    input wire logic deconfigured,
    input wire logic in_low_power,
    // Wake and resume events
    input wire pmc_pkg::pmc_wake_t wake_ev,
    input wire pmc_pkg::pmc_resume_t resume,
    // Controls to the rest of the device
    output logic [1:0] suspend_state,
    output logic clear_mac_wake_status,
    output logic phy_reset,
    output logic usb_nak,
    output logic irq
);
    function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
        hit = (adr[7:2] == ofs[7:2]);
    endfunction : hit

    pmc_pkg::pmc_ctl_t ctl_reg;
    pmc_pkg::pmc_ctl_t ctl_next;
    logic [15:0] tx_free_reg;
    logic ready_reg;
    logic energy_arm_reg;
    logic lan_arm_reg;
    logic lp_q_reg;
    logic [pmc_pkg::IRQ_W-1:0] irq_sts_reg;
    logic [pmc_pkg::IRQ_W-1:0] irq_mask_reg;
    logic [pmc_pkg::IRQ_W-1:0] irq_sts_next;
    logic phy_busy;
    logic phy_done;

    // Bus decode; a write lands at the edge where ack is seen by the master
    wire logic req = wb_cyc_i & wb_stb_i;
    wire logic wr = req & wb_we_i & wb_ack_o;
    wire logic hit_tx = hit(wb_adr_i, pmc_pkg::TX_INFO_OFS);
    wire logic hit_ctl = hit(wb_adr_i, pmc_pkg::CTL_OFS);
    wire logic hit_sts = hit(wb_adr_i, pmc_pkg::IRQ_STS_OFS);
    wire logic hit_msk = hit(wb_adr_i, pmc_pkg::IRQ_MASK_OFS);
    wire logic wr_ctl_lo = wr & hit_ctl & wb_sel_i[0];
    wire logic wr_ctl_hi = wr & hit_ctl & wb_sel_i[1];
    wire logic wr_sts = wr & hit_sts & wb_sel_i[0];
    wire logic wr_msk = wr & hit_msk & wb_sel_i[0];

    // Wake recording uses enables captured at low power entry
    wire logic lp_entry = in_low_power & ~lp_q_reg;
    wire logic lan_src = wake_ev.lan | (HAS_STATE3 & wake_ev.good_frame);
    wire logic energy_hit = in_low_power & energy_arm_reg & wake_ev.energy;
    wire logic lan_hit = in_low_power & lan_arm_reg & lan_src;
    wire logic [1:0] cause_set = (energy_hit ? pmc_pkg::CAUSE_ENERGY : pmc_pkg::CAUSE_NONE)
        | (lan_hit ? pmc_pkg::CAUSE_LAN : pmc_pkg::CAUSE_NONE);
    wire logic cause_w1c = wr_ctl_lo & (|wb_dat_i[pmc_pkg::CAUSE_LSB +: 2]);
    wire logic frame_resume = resume.done & resume.by_frame;
    wire logic sts_clear = frame_resume & ctl_reg.clr_sts;
    wire logic en_clear = resume.done & resume.by_remote & ctl_reg.clr_en;
    wire logic phy_start = wr_ctl_lo & wb_dat_i[pmc_pkg::PHY_RESET_REQUEST_BIT] & ~phy_busy;
    wire logic ready_next = in_normal & hw_cfg_done & (phy_clk_ok | watchdog_expired);

    // Next value of the control register
    always_comb begin
        ctl_next = ctl_reg;
        if (wr_ctl_lo) begin
            ctl_next.susp_sel = wb_dat_i[pmc_pkg::SUSP_LSB +: 2];
            ctl_next.lan_en = wb_dat_i[pmc_pkg::LAN_EN_BIT];
            ctl_next.energy_en = wb_dat_i[pmc_pkg::ENERGY_EN_BIT];
        end
        if (wr_ctl_hi) begin
            ctl_next.clr_en = wb_dat_i[pmc_pkg::CLR_EN_BIT];
            ctl_next.clr_sts = wb_dat_i[pmc_pkg::CLR_STS_BIT];
        end
        if (deconfigured) begin
            ctl_next.susp_sel = pmc_pkg::SUSP_RST;
        end
        if (en_clear) begin
            ctl_next.lan_en = 1'b0;
            ctl_next.energy_en = 1'b0;
        end
        if (cause_w1c) begin
            ctl_next.cause = pmc_pkg::CAUSE_NONE;
        end
        if (sts_clear) begin
            ctl_next.cause[1] = 1'b0;
        end
        // A new wake event wins over any clear in the same cycle
        ctl_next.cause = ctl_next.cause | cause_set;
    end

    always_comb begin
        irq_sts_next = irq_sts_reg;
        if (wr_sts) begin
            irq_sts_next = irq_sts_reg & ~wb_dat_i[pmc_pkg::IRQ_W-1:0];
        end
        irq_sts_next[pmc_pkg::IRQ_WAKE] = irq_sts_next[pmc_pkg::IRQ_WAKE] | (|cause_set);
        irq_sts_next[pmc_pkg::IRQ_PHY] = irq_sts_next[pmc_pkg::IRQ_PHY] | phy_done;
        irq_sts_next[pmc_pkg::IRQ_READY] = irq_sts_next[pmc_pkg::IRQ_READY]
            | (ready_next & ~ready_reg);
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ctl_reg <= '{clr_sts: pmc_pkg::CLR_STS_RST, clr_en: pmc_pkg::CLR_EN_RST,
                susp_sel: pmc_pkg::SUSP_RST, lan_en: 1'b0, energy_en: 1'b0,
                cause: pmc_pkg::CAUSE_NONE};
            tx_free_reg <= pmc_pkg::TX_FREE_RST;
            ready_reg <= 1'b0;
            energy_arm_reg <= 1'b0;
            lan_arm_reg <= 1'b0;
            lp_q_reg <= 1'b0;
            irq_sts_reg <= '0;
            irq_mask_reg <= '0;
            clear_mac_wake_status <= 1'b0;
        end else begin
            ctl_reg <= ctl_next;
            tx_free_reg <= tx_free_bytes;
            ready_reg <= ready_next;
            lp_q_reg <= in_low_power;
            irq_sts_reg <= irq_sts_next;
            clear_mac_wake_status <= sts_clear;
            if (wr_msk) begin
                irq_mask_reg <= wb_dat_i[pmc_pkg::IRQ_W-1:0];
            end
            if (lp_entry) begin
                energy_arm_reg <= ctl_reg.energy_en;
                lan_arm_reg <= ctl_reg.lan_en;
            end
        end
    end

    // Read mux; reserved and unmapped bits read as zero
    wire logic [31:0] ctl_rd = {22'h0, ctl_reg.clr_sts, ctl_reg.clr_en, ready_reg,
        ctl_reg.susp_sel, phy_busy, ctl_reg.lan_en, ctl_reg.energy_en, ctl_reg.cause};
    wire logic [31:0] rd_data = hit_tx ? {16'h0, tx_free_reg} :
        hit_ctl ? ctl_rd :
        hit_sts ? {29'h0, irq_sts_reg} :
        hit_msk ? {29'h0, irq_mask_reg} : 32'h0;

    // One wait state; ack drops the cycle after it was given
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= req & ~wb_ack_o;
            wb_dat_o <= rd_data;
        end
    end

    pmc_hold_timer #(
        .CYCLES(PHY_RESET_REQUEST_CYCLES)
    ) u_phy_timer (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .start(phy_start),
        .busy(phy_busy),
        .done(phy_done)
    );

    // Code 11 maps by variant; the driver must still only use state two unconfigured
    assign suspend_state = (ctl_reg.susp_sel == pmc_pkg::SUSP_THREE && !HAS_STATE3) ?
        pmc_pkg::SUSP_TWO : ctl_reg.susp_sel;
    assign phy_reset = phy_busy;
    assign usb_nak = phy_busy;
    assign irq = |(irq_sts_reg & irq_mask_reg);

    sequence s_phy_go;
        phy_start;
    endsequence

    sequence s_phy_hold;
        (phy_reset && usb_nak)[*8];
    endsequence

    property p_phy_hold;
        @(posedge core_clk) disable iff (sys_rst)
        s_phy_go |=> s_phy_hold;
    endproperty
    a_phy_hold: assert property (p_phy_hold) else $error("PHY reset too short");

    property p_phy_ignore;
        @(posedge core_clk) disable iff (sys_rst)
        (phy_busy && !phy_done && wr_ctl_lo) |=> phy_busy || phy_done;
    endproperty
    a_phy_ignore: assert property (p_phy_ignore) else $error("PHY write not ignored");

    property p_nak;
        @(posedge core_clk) disable iff (sys_rst)
        $fell(phy_reset) |-> phy_done && !usb_nak;
    endproperty
    a_nak: assert property (p_nak) else $error("NAK not tied to PHY reset");

    property p_tx_free;
        @(posedge core_clk) disable iff (sys_rst)
        !$past(sys_rst) |-> tx_free_reg == $past(tx_free_bytes);
    endproperty
    a_tx_free: assert property (p_tx_free) else $error("TX free bytes stale");

    property p_frame_clear;
        @(posedge core_clk) disable iff (sys_rst)
        (sts_clear && !lan_hit) |=> !ctl_reg.cause[1] && clear_mac_wake_status;
    endproperty
    a_frame_clear: assert property (p_frame_clear) else $error("Wake status kept");

    property p_host_resume;
        @(posedge core_clk) disable iff (sys_rst)
        (resume.done && !resume.by_frame && !cause_w1c && cause_set == 2'h0)
            |=> ctl_reg.cause == $past(ctl_reg.cause);
    endproperty
    a_host_resume: assert property (p_host_resume) else $error("Cause changed");

    property p_en_clear;
        @(posedge core_clk) disable iff (sys_rst)
        en_clear |=> !ctl_reg.lan_en && !ctl_reg.energy_en;
    endproperty
    a_en_clear: assert property (p_en_clear) else $error("Enables kept");

    property p_ready;
        @(posedge core_clk) disable iff (sys_rst)
        ready_reg |-> $past(in_normal && hw_cfg_done && (phy_clk_ok || watchdog_expired));
    endproperty
    a_ready: assert property (p_ready) else $error("Ready set early");

    property p_deconfig;
        @(posedge core_clk) disable iff (sys_rst)
        deconfigured |=> ctl_reg.susp_sel == 2'h2;
    endproperty
    a_deconfig: assert property (p_deconfig) else $error("Suspend select not forced");

    property p_w1c;
        @(posedge core_clk) disable iff (sys_rst)
        (cause_w1c && cause_set == 2'h0) |=> ctl_reg.cause == 2'h0;
    endproperty
    a_w1c: assert property (p_w1c) else $error("Wake cause not cleared");

    property p_armed;
        @(posedge core_clk) disable iff (sys_rst)
        (in_low_power && !energy_arm_reg && !lan_arm_reg && !cause_w1c && !sts_clear)
            |=> ctl_reg.cause == $past(ctl_reg.cause);
    endproperty
    a_armed: assert property (p_armed) else $error("Unarmed cause recorded");

    property p_nak_start;
        @(posedge core_clk) disable iff (sys_rst)
        $rose(usb_nak) |-> $past(phy_start);
    endproperty
    a_nak_start: assert property (p_nak_start) else $error("NAK without PHY reset");

    // Length of the running PHY hold, so the exact count can be checked
    logic [31:0] hold_len_reg;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            hold_len_reg <= 32'h0;
        end else if (phy_busy) begin
            hold_len_reg <= hold_len_reg + 32'h1;
        end else begin
            hold_len_reg <= 32'h0;
        end
    end

    property p_hold_len;
        @(posedge core_clk) disable iff (sys_rst)
        $fell(phy_busy) |-> hold_len_reg == 32'(PHY_RESET_REQUEST_CYCLES);
    endproperty
    a_hold_len: assert property (p_hold_len) else $error("PHY hold length wrong");

    property p_lan_cause;
        @(posedge core_clk) disable iff (sys_rst)
        lan_hit |=> ctl_reg.cause[1];
    endproperty
    a_lan_cause: assert property (p_lan_cause) else $error("LAN wake not recorded");

    property p_energy_cause;
        @(posedge core_clk) disable iff (sys_rst)
        energy_hit |=> ctl_reg.cause[0];
    endproperty
    a_energy_cause: assert property (p_energy_cause) else $error("Energy wake lost");

    property p_arm;
        @(posedge core_clk) disable iff (sys_rst)
        lp_entry |=> energy_arm_reg == $past(ctl_reg.energy_en)
            && lan_arm_reg == $past(ctl_reg.lan_en);
    endproperty
    a_arm: assert property (p_arm) else $error("Wake enables not captured");

    property p_not_ready;
        @(posedge core_clk) disable iff (sys_rst)
        !in_normal |=> !ready_reg;
    endproperty
    a_not_ready: assert property (p_not_ready) else $error("Ready outside normal state");

    property p_susp_wr;
        @(posedge core_clk) disable iff (sys_rst)
        (wr_ctl_lo && !deconfigured)
            |=> ctl_reg.susp_sel == $past(wb_dat_i[pmc_pkg::SUSP_LSB +: 2]);
    endproperty
    a_susp_wr: assert property (p_susp_wr) else $error("Suspend select not written");

    property p_no_clear;
        @(posedge core_clk) disable iff (sys_rst)
        !sts_clear |=> !clear_mac_wake_status;
    endproperty
    a_no_clear: assert property (p_no_clear) else $error("Wake status cleared wrongly");

    property p_rsvd;
        @(posedge core_clk) disable iff (sys_rst)
        (wb_ack_o && hit_ctl) |-> wb_dat_o[31:10] == 22'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("Reserved bits not zero");
endmodule : pmc_ctrl

// file: core/_unused_placeholder_removed.sv
// Spare design unit that holds no logic
`timescale 1ns/10ps

// file: test/tb_top.sv
// Self-checking bench for the power management control block
`timescale 1ns/10ps
module tb_top;
    logic core_clk = 0, sys_rst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic [7:0] wb_adr_i = 0;
    logic [3:0] wb_sel_i = 0;
    logic [31:0] wb_dat_i = 0, wb_dat_o, q;
    logic wb_ack_o, phy_reset, usb_nak, irq, clear_mac_wake_status;
    logic [15:0] tx_free_bytes = 0;
    logic in_normal = 0, hw_cfg_done = 0, phy_clk_ok = 0, watchdog_expired = 0;
    logic deconfigured = 0, in_low_power = 0;
    logic [1:0] suspend_state;
    pmc_pkg::pmc_wake_t wake_ev = '0;
    pmc_pkg::pmc_resume_t resume = '0;
    int errors = 0, comparisons = 0, seed = 32'h50de, phy_cnt = 0, nak_cnt = 0, c0, c1;
    // Model of the control register
    logic [1:0] m_susp, m_cause;
    logic m_clr_sts, m_clr_en, m_ready, m_lan, m_en;

    always #4 core_clk = ~core_clk;

    // Cycles spent in PHY reset and NAK, so a restarted hold shows up
    always @(posedge core_clk) begin
        phy_cnt <= phy_cnt + (phy_reset === 1'b1);
        nak_cnt <= nak_cnt + (usb_nak === 1'b1);
    end

    pmc_ctrl #(.PHY_RESET_REQUEST_CYCLES(16)) u_pmc_ctrl (.core_clk(core_clk), .sys_rst(sys_rst),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .tx_free_bytes(tx_free_bytes), .in_normal(in_normal), .hw_cfg_done(hw_cfg_done),
        .phy_clk_ok(phy_clk_ok), .watchdog_expired(watchdog_expired),
        .deconfigured(deconfigured), .in_low_power(in_low_power), .wake_ev(wake_ev),
        .resume(resume), .suspend_state(suspend_state),
        .clear_mac_wake_status(clear_mac_wake_status), .phy_reset(phy_reset),
        .usb_nak(usb_nak), .irq(irq));

    task report_and_stop;
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop

    task check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // Classic cycle: hold everything until ack is sampled, then release
    task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'hf;
        wb_dat_i <= d;
        // No limit of its own: a hung cycle is ended by the watchdog
        do begin
            @(posedge core_clk);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask : wb

    function automatic logic [31:0] ctl_exp(input logic phy);
        return {22'h0, m_clr_sts, m_clr_en, m_ready, m_susp, phy, m_lan, m_en, m_cause};
    endfunction : ctl_exp

    task ctl_wr(input logic [31:0] d);
        wb(1'b1, pmc_pkg::CTL_OFS, d);
        m_clr_sts = d[9];
        m_clr_en = d[8];
        m_susp = d[6:5];
        m_lan = d[3];
        m_en = d[2];
        if (d[1:0] != 2'h0)
            m_cause = 2'h0;
    endtask : ctl_wr

    task ctl_chk(input logic phy);
        wb(1'b0, pmc_pkg::CTL_OFS, 32'h0);
        check(q, ctl_exp(phy));
    endtask : ctl_chk

    task pulse(input pmc_pkg::pmc_wake_t w, input pmc_pkg::pmc_resume_t r);
        @(posedge core_clk);
        wake_ev <= w;
        resume <= r;
        @(posedge core_clk);
        wake_ev <= '0;
        resume <= '0;
    endtask : pulse

    initial begin
        #400000;
        errors++;
        report_and_stop;
    end

    initial begin
        m_clr_sts = 0;
        m_clr_en = 1;
        m_ready = 0;
        m_susp = 2'h2;
        m_lan = 0;
        m_en = 0;
        m_cause = 0;
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
        tx_free_bytes <= 16'($random(seed));
        ctl_chk(1'b0);
        check(32'(suspend_state), 32'h2);
        wb(1'b0, pmc_pkg::TX_INFO_OFS, 32'h0);
        check(q, {16'h0, tx_free_bytes});
        wb(1'b0, 8'h30, 32'hffffffff);
        check(q, 32'h0);
        // Every suspend code, random enables, reserved and read-only bits written high
        for (int i = 0; i < 4; i++) begin
            ctl_wr(32'hfffffc80 | (i << 5) | ($random(seed) & 32'h30c));
            ctl_chk(1'b0);
            check(32'(suspend_state), i);
        end
        @(posedge core_clk);
        deconfigured <= 1'b1;
        @(posedge core_clk);
        deconfigured <= 1'b0;
        m_susp = 2'h2;
        ctl_chk(1'b0);
        // A second request or a zero write must not restart or cut the hold
        c0 = phy_cnt;
        c1 = nak_cnt;
        ctl_wr(ctl_exp(1'b0) | 32'h10);
        ctl_chk(1'b1);
        ctl_wr(ctl_exp(1'b0) | 32'h10);
        ctl_wr(ctl_exp(1'b0));
        ctl_chk(1'b1);
        for (int n = 0; n < 100 && phy_reset === 1'b1; n++)
            @(posedge core_clk);
        check(phy_cnt - c0, 16);
        check(nak_cnt - c1, 16);
        ctl_chk(1'b0);
        wb(1'b0, pmc_pkg::IRQ_STS_OFS, 32'h0);
        check(q, 32'h2);
        wb(1'b1, pmc_pkg::IRQ_STS_OFS, 32'h7);
        in_normal <= 1'b1;
        hw_cfg_done <= 1'b1;
        ctl_chk(1'b0);
        watchdog_expired <= 1'b1;
        repeat (2) @(posedge core_clk);
        m_ready = 1;
        ctl_chk(1'b0);
        wb(1'b1, pmc_pkg::IRQ_STS_OFS, 32'h7);
        wb(1'b1, pmc_pkg::IRQ_MASK_OFS, 32'h1);
        // Only energy armed: a LAN event leaves no cause
        ctl_wr(32'h44);
        in_low_power <= 1'b1;
        pulse(3'b010, 3'b000);
        ctl_chk(1'b0);
        check(irq, 1'b0);
        pulse(3'b100, 3'b000);
        m_cause = 2'h1;
        ctl_chk(1'b0);
        check(irq, 1'b1);
        in_low_power <= 1'b0;
        ctl_wr(32'h4c);
        in_low_power <= 1'b1;
        pulse(3'b010, 3'b000);
        m_cause = 2'h3;
        ctl_chk(1'b0);
        ctl_wr(32'h4c);
        ctl_chk(1'b0);
        ctl_wr(32'h4d);
        ctl_chk(1'b0);
        in_low_power <= 1'b0;
        wb(1'b1, pmc_pkg::IRQ_STS_OFS, 32'h1);
        // Status clears at the edge that ends the write, so look after it settles
        @(negedge core_clk);
        check(irq, 1'b0);
        // Resume clearing: host resume, frame resume, remote resume
        ctl_wr(32'h34c);
        in_low_power <= 1'b1;
        pulse(3'b010, 3'b000);
        m_cause = 2'h2;
        in_low_power <= 1'b0;
        pulse(3'b000, 3'b100);
        ctl_chk(1'b0);
        pulse(3'b000, 3'b110);
        @(negedge core_clk);
        check(clear_mac_wake_status, 1'b1);
        m_cause = 2'h0;
        ctl_chk(1'b0);
        pulse(3'b000, 3'b101);
        m_lan = 0;
        m_en = 0;
        ctl_chk(1'b0);
        // With the clear bit off a frame resume leaves the cause
        ctl_wr(32'h14c);
        in_low_power <= 1'b1;
        pulse(3'b001, 3'b000);
        m_cause = 2'h2;
        in_low_power <= 1'b0;
        pulse(3'b000, 3'b110);
        ctl_chk(1'b0);
        report_and_stop;
    end
endmodule : tb_top
